// >>> hw/ilte_pkg.sv
// constants, register map and state codes of the link test engine
// assumes a 100 MHz system clock and word-indexed register offsets
package ilte_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_TARGET  = 6'h00;
  localparam logic [5:0] IDX_LENGTH  = 6'h01;
  localparam logic [5:0] IDX_TIMEOUT = 6'h02;
  localparam logic [5:0] IDX_STATUS  = 6'h03;
  localparam logic [5:0] IDX_RUNS    = 6'h04;
  localparam logic [5:0] IDX_CNT_TOP = 6'h08;
  localparam logic [5:0] IDX_CTRL    = 6'h09;

  // ****************************************************************
  // fields
  // ****************************************************************
  localparam int         START_BIT  = 1;
  localparam int         CODE_LSB   = 13;
  localparam int         NUM_CNT    = 5;
  localparam int         NUM_FLAGS  = 6;
  localparam logic [7:0] NET_MIN    = 8'h01;
  localparam logic [7:0] NET_MAX    = 8'h7F;
  localparam logic [7:0] NODE_MIN   = 8'h01;
  localparam logic [7:0] NODE_MAX   = 8'h7E;
  localparam logic [15:0] LEN_MAX   = 16'h07CC;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;

  // ****************************************************************
  // result codes
  // ****************************************************************
  localparam logic [2:0] RES_NORMAL   = 3'h0;
  localparam logic [2:0] RES_TIMEOUT  = 3'h1;
  localparam logic [2:0] RES_RESPONSE = 3'h2;
  localparam logic [2:0] RES_SEND     = 3'h3;
  localparam logic [2:0] RES_MISMATCH = 3'h4;
  localparam logic [2:0] RES_ROUTE    = 3'h5;
  localparam logic [2:0] RES_PARAM    = 3'h6;

  // ****************************************************************
  // word addresses of the parameter block and control word
  // ****************************************************************
  localparam int DATA_AREA_BASE = 2000;
  localparam int DATA_STRIDE    = 100;
  localparam int CTRL_BASE      = 1500;
  localparam int CTRL_STRIDE    = 25;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TMO_UNIT_MS     = 10;
  localparam int TMO_DEFAULT_MS  = 2000;
  localparam int TMO_UNIT_CYCLES = TMO_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [15:0] TMO_DEFAULT_UNITS = 16'(TMO_DEFAULT_MS / TMO_UNIT_MS);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_SEND  = 4'b0100,
    ST_WAIT  = 4'b1000
  } ilte_state_e;

endpackage : ilte_pkg

// >>> hw/ilte_engine.sv
// link test engine: APB register block, frame sender, echo checker, counters
// assumes single clock; frame and response ports run on the same clock
`timescale 1ns/1ns

module ilte_engine #(
  parameter int UNIT_NUMBER     = 0,
  parameter int ADDR_W          = 8,
  parameter int TMO_UNIT_CYCLES = ilte_pkg::TMO_UNIT_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   txValid,
  input  wire logic              txReady,
  output logic [7:0]             txData,
  output logic                   txLast,
  output logic [15:0]            txDest,
  input  wire logic              sendFail,
  input  wire logic              routeFail,
  input  wire logic              rxValid,
  input  wire logic [7:0]        rxData,
  input  wire logic              rxLast,
  input  wire logic              rxCodeOk,
  output logic                   testRunningIndicator,
  output logic [15:0]            paramBlockWord,
  output logic [15:0]            ctrlWordAddr
);

  // ****************************************************************
  // register block state
  // ****************************************************************
  logic [15:0] paramTarget, paramLength, paramTimeout;
  logic        startBit;
  logic [15:0] next_paramTarget, next_paramLength, next_paramTimeout;
  logic        next_startBit;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [5:0]  regIdx;
  logic        addrBad;

  // ****************************************************************
  // engine state
  // ****************************************************************
  ilte_pkg::ilte_state_e state, next_state;
  logic [15:0] cnt [ilte_pkg::NUM_CNT];
  logic [15:0] next_cnt [ilte_pkg::NUM_CNT];
  logic [2:0]  code, next_code;
  logic [ilte_pkg::NUM_FLAGS-1:0] flags, next_flags;
  logic [10:0] curLen, next_curLen, txIdx, next_txIdx, rxIdx, next_rxIdx;
  logic [15:0] curTmo, next_curTmo, unitCnt, next_unitCnt;
  logic [31:0] tickCnt, next_tickCnt;
  logic [15:0] curDest, next_curDest;
  logic [7:0]  seed, next_seed;
  logic        mism, next_mism;
  logic        done;
  logic [2:0]  doneCode;
  logic        paramBad;
  logic [15:0] lenEff, tmoEff;

  assign regIdx = paddr[7:2];
  assign addrBad = (paddr[1:0] != 2'h0) || (regIdx > ilte_pkg::IDX_CTRL)
                   || ((paddr >> 8) != '0);
  assign pready  = psel & penable;

  // ****************************************************************
  // APB slave: read data captured in setup, write in access
  // ****************************************************************
  always_comb begin
    next_paramTarget  = paramTarget;
    next_paramLength  = paramLength;
    next_paramTimeout = paramTimeout;
    next_startBit     = startBit;
    next_prdata       = prdata;
    next_pslverr      = pslverr;
    if (psel && !penable) begin
      next_pslverr = addrBad;
      next_prdata  = 32'h0;
      if (!addrBad) begin
        case (regIdx)
          ilte_pkg::IDX_TARGET:  next_prdata = {16'h0, paramTarget};
          ilte_pkg::IDX_LENGTH:  next_prdata = {16'h0, paramLength};
          ilte_pkg::IDX_TIMEOUT: next_prdata = {16'h0, paramTimeout};
          ilte_pkg::IDX_STATUS:  next_prdata = {16'h0, code, 7'h0, flags};
          ilte_pkg::IDX_CTRL:    next_prdata = {30'h0, startBit, 1'b0};
          default: begin
            if (regIdx >= ilte_pkg::IDX_RUNS && regIdx <= ilte_pkg::IDX_CNT_TOP)
              next_prdata = {16'h0, cnt[3'(regIdx - ilte_pkg::IDX_RUNS)]};
          end
        endcase
      end
    end
    if (pready && pwrite && !addrBad) begin
      case (regIdx)
        ilte_pkg::IDX_TARGET:  next_paramTarget  = pwdata[15:0];
        ilte_pkg::IDX_LENGTH:  next_paramLength  = pwdata[15:0];
        ilte_pkg::IDX_TIMEOUT: next_paramTimeout = pwdata[15:0];
        ilte_pkg::IDX_CTRL:    next_startBit     = pwdata[ilte_pkg::START_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      paramTarget  <= 16'h0000;
      paramLength  <= 16'h0000;
      paramTimeout <= 16'h0000;
      startBit     <= 1'b0;
      prdata       <= 32'h0000_0000;
      pslverr      <= 1'b0;
    end else begin
      paramTarget  <= next_paramTarget;
      paramLength  <= next_paramLength;
      paramTimeout <= next_paramTimeout;
      startBit     <= next_startBit;
      prdata       <= next_prdata;
      pslverr      <= next_pslverr;
    end
  end

  // ****************************************************************
  // live parameters, checked at the start of each exchange
  // ****************************************************************
  assign lenEff = (paramLength == 16'h0000) ? ilte_pkg::LEN_MAX : paramLength;
  assign tmoEff = (paramTimeout == 16'h0000) ? ilte_pkg::TMO_DEFAULT_UNITS : paramTimeout;
  assign paramBad = (paramTarget[15:8] < ilte_pkg::NET_MIN) || (paramTarget[15:8] > ilte_pkg::NET_MAX)
                    || (paramTarget[7:0] < ilte_pkg::NODE_MIN) || (paramTarget[7:0] > ilte_pkg::NODE_MAX)
                    || (paramLength > ilte_pkg::LEN_MAX);

  assign txValid = (state == ilte_pkg::ST_SEND);
  assign txData  = txIdx[7:0] ^ seed;
  assign txLast  = (txIdx == curLen - 11'h001);
  assign txDest  = curDest;

  // ****************************************************************
  // exchange sequencer
  // ****************************************************************
  always_comb begin
    next_state   = state;
    next_code    = code;
    next_flags   = flags;
    next_curLen  = curLen;
    next_curTmo  = curTmo;
    next_curDest = curDest;
    next_seed    = seed;
    next_txIdx   = txIdx;
    next_rxIdx   = rxIdx;
    next_mism    = mism;
    next_unitCnt = unitCnt;
    next_tickCnt = tickCnt;
    for (int i = 0; i < ilte_pkg::NUM_CNT; i++) next_cnt[i] = cnt[i];
    done     = 1'b0;
    doneCode = ilte_pkg::RES_NORMAL;
    case (state)
      ilte_pkg::ST_IDLE: begin
        if (startBit) begin
          next_flags = '0;
          for (int i = 0; i < ilte_pkg::NUM_CNT; i++) next_cnt[i] = 16'h0000;
          next_state = ilte_pkg::ST_CHECK;
        end
      end
      ilte_pkg::ST_CHECK: begin
        next_curLen  = lenEff[10:0];
        next_curTmo  = tmoEff;
        next_curDest = paramTarget;
        next_seed    = cnt[0][7:0];
        next_txIdx   = 11'h000;
        next_rxIdx   = 11'h000;
        next_mism    = 1'b0;
        if (paramBad) begin
          done     = 1'b1;
          doneCode = ilte_pkg::RES_PARAM;
        end else begin
          next_state = ilte_pkg::ST_SEND;
        end
      end
      ilte_pkg::ST_SEND: begin
        if (routeFail) begin
          done     = 1'b1;
          doneCode = ilte_pkg::RES_ROUTE;
        end else if (sendFail) begin
          done     = 1'b1;
          doneCode = ilte_pkg::RES_SEND;
        end else if (txReady) begin
          next_txIdx = txIdx + 11'h001;
          if (txLast) begin
            next_state   = ilte_pkg::ST_WAIT;
            next_unitCnt = 16'h0000;
            next_tickCnt = 32'h0;
          end
        end
      end
      ilte_pkg::ST_WAIT: begin
        if (sendFail) begin
          done     = 1'b1;
          doneCode = ilte_pkg::RES_SEND;
        end else if (rxValid) begin
          next_rxIdx = rxIdx + 11'h001;
          if (rxData != (rxIdx[7:0] ^ seed) || rxIdx >= curLen)
            next_mism = 1'b1;
          if (rxLast) begin
            done = 1'b1;
            if (!rxCodeOk)
              doneCode = ilte_pkg::RES_RESPONSE;
            else if (next_mism || next_rxIdx != curLen)
              doneCode = ilte_pkg::RES_MISMATCH;
            else
              doneCode = ilte_pkg::RES_NORMAL;
          end
        end else if (tickCnt == 32'(TMO_UNIT_CYCLES - 1)) begin
          next_tickCnt = 32'h0;
          next_unitCnt = unitCnt + 16'h0001;
          if (next_unitCnt == curTmo) begin
            done     = 1'b1;
            doneCode = ilte_pkg::RES_TIMEOUT;
          end
        end else begin
          next_tickCnt = tickCnt + 32'h1;
        end
      end
      default: next_state = ilte_pkg::ST_IDLE;
    endcase
    if (done) begin
      next_code  = doneCode;
      next_state = ilte_pkg::ST_CHECK;
      next_cnt[0] = cnt[0] + 16'h0001;
      if (doneCode != ilte_pkg::RES_NORMAL)
        next_flags[doneCode - 3'h1] = 1'b1;
      if (doneCode >= ilte_pkg::RES_TIMEOUT && doneCode <= ilte_pkg::RES_MISMATCH
          && cnt[doneCode] != ilte_pkg::CNT_MAX)
        next_cnt[doneCode] = cnt[doneCode] + 16'h0001;
    end
    if (!startBit)
      next_state = ilte_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= ilte_pkg::ST_IDLE;
      code    <= 3'h0;
      flags   <= '0;
      curLen  <= 11'h000;
      curTmo  <= 16'h0000;
      curDest <= 16'h0000;
      seed    <= 8'h00;
      txIdx   <= 11'h000;
      rxIdx   <= 11'h000;
      mism    <= 1'b0;
      unitCnt <= 16'h0000;
      tickCnt <= 32'h0;
      for (int i = 0; i < ilte_pkg::NUM_CNT; i++) cnt[i] <= 16'h0000;
      testRunningIndicator <= 1'b0;
      paramBlockWord       <= 16'h0000;
      ctrlWordAddr         <= 16'h0000;
    end else begin
      state   <= next_state;
      code    <= next_code;
      flags   <= next_flags;
      curLen  <= next_curLen;
      curTmo  <= next_curTmo;
      curDest <= next_curDest;
      seed    <= next_seed;
      txIdx   <= next_txIdx;
      rxIdx   <= next_rxIdx;
      mism    <= next_mism;
      unitCnt <= next_unitCnt;
      tickCnt <= next_tickCnt;
      for (int i = 0; i < ilte_pkg::NUM_CNT; i++) cnt[i] <= next_cnt[i];
      testRunningIndicator <= startBit;
      paramBlockWord <= 16'(ilte_pkg::DATA_AREA_BASE + ilte_pkg::DATA_STRIDE * UNIT_NUMBER);
      ctrlWordAddr   <= 16'(ilte_pkg::CTRL_BASE + ilte_pkg::CTRL_STRIDE * UNIT_NUMBER);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // counters and status
  a_run_wrap: assert property (done && cnt[0] == 16'hFFFF |=> cnt[0] == 16'h0000)
    else $error("run counter did not wrap");
  a_run_count: assert property (done |=> cnt[0] == 16'($past(cnt[0]) + 16'h0001))
    else $error("run counter did not advance");
  a_err_saturate: assert property (done && doneCode == ilte_pkg::RES_TIMEOUT && cnt[1] == 16'hFFFF
                                   && startBit |=> cnt[1] == 16'hFFFF)
    else $error("timeout counter left saturation");
  a_mismatch_count: assert property (done && doneCode == ilte_pkg::RES_MISMATCH
                                     && cnt[4] != ilte_pkg::CNT_MAX |=> cnt[4] == 16'($past(cnt[4]) + 16'h0001))
    else $error("mismatch counter did not advance");
  a_no_count_cfg: assert property (done && doneCode >= ilte_pkg::RES_ROUTE
                                   |=> $stable(cnt[1]) && $stable(cnt[2]) && $stable(cnt[3]) && $stable(cnt[4]))
    else $error("error counter moved on routing or parameter error");
  a_status_update: assert property (done |=> code == $past(doneCode))
    else $error("status code not updated");
  a_start_clear: assert property (state == ilte_pkg::ST_IDLE && startBit
                                  |=> cnt[0] == 16'h0000 && flags == '0 && state == ilte_pkg::ST_CHECK)
    else $error("start did not clear counters");
  a_indicator: assert property ($rose(startBit) |=> testRunningIndicator [*2])
    else $error("indicator not on while running");
  a_indicator_off: assert property (!startBit |=> !testRunningIndicator)
    else $error("indicator on while stopped");
  a_stop_halt: assert property (!startBit |=> state == ilte_pkg::ST_IDLE && !txValid)
    else $error("engine did not halt");
  a_hold_stopped: assert property (state == ilte_pkg::ST_IDLE && !startBit
                                   |=> $stable(code) && $stable(cnt[0]) && $stable(flags))
    else $error("results changed while stopped");
  a_timeout_code: assert property (state == ilte_pkg::ST_WAIT && startBit && !rxValid && !sendFail
                                   && tickCnt == 32'(TMO_UNIT_CYCLES - 1) && unitCnt + 16'h0001 == curTmo
                                   |=> code == ilte_pkg::RES_TIMEOUT && flags[0])
    else $error("timeout not reported");
  a_flag_sticky: assert property (flags[3] && !(state == ilte_pkg::ST_IDLE && startBit) |=> flags[3])
    else $error("error flag dropped");

  // bus, parameters and link results
  a_bad_addr: assert property (psel && !penable && addrBad |=> pslverr && prdata == 32'h0000_0000)
    else $error("bad address not refused");
  a_tx_hold: assert property (txValid && !txReady |=> $stable(txData) && $stable(txDest))
    else $error("offered byte changed before it was taken");
  a_len_live: assert property (state == ilte_pkg::ST_CHECK |=> curLen == 11'($past(lenEff)))
    else $error("frame length not taken from live parameter");
  a_len_default: assert property (state == ilte_pkg::ST_CHECK && paramLength == 16'h0000
                                  |=> curLen == 11'(ilte_pkg::LEN_MAX))
    else $error("zero length did not select the maximum");
  a_tmo_default: assert property (state == ilte_pkg::ST_CHECK && paramTimeout == 16'h0000
                                  |=> curTmo == ilte_pkg::TMO_DEFAULT_UNITS)
    else $error("zero timeout did not select the default");
  a_param_result: assert property (state == ilte_pkg::ST_CHECK && paramBad
                                   |=> code == ilte_pkg::RES_PARAM && !txValid)
    else $error("illegal parameters not reported");
  a_route_result: assert property (state == ilte_pkg::ST_SEND && routeFail |=> code == ilte_pkg::RES_ROUTE)
    else $error("routing failure not reported");
  a_send_result: assert property (state == ilte_pkg::ST_SEND && !routeFail && sendFail
                                  |=> code == ilte_pkg::RES_SEND)
    else $error("send failure not reported");

  c_normal: cover property (done && doneCode == ilte_pkg::RES_NORMAL);
  c_timeout: cover property (done && doneCode == ilte_pkg::RES_TIMEOUT);
  c_mismatch: cover property (done && doneCode == ilte_pkg::RES_MISMATCH);
  c_param_error: cover property (done && doneCode == ilte_pkg::RES_PARAM);
  c_stop_run: cover property (state == ilte_pkg::ST_WAIT ##1 !startBit);

endmodule : ilte_engine

// >>> bench/ilte_remote.sv
// remote node model: takes each test frame and echoes it back
// assumes the engine's link ports share its clock; mode picks the fault
`timescale 1ns/1ns
module ilte_remote (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] mode,
  input  wire logic       slow,
  input  wire logic       txValid,
  output logic            txReady,
  input  wire logic [7:0] txData,
  input  wire logic       txLast,
  output logic            sendFail,
  output logic            routeFail,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxLast,
  output logic            rxCodeOk
);
  logic [7:0] held[$];
  logic       echo;
  logic       tog;

  // ****************************************************************
  // modes: 1 silent, 2 bad code, 3 corrupt, 4 send fail, 5 route fail
  // ****************************************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      held.delete();
      echo      <= 1'b0;
      tog       <= 1'b0;
      txReady   <= 1'b0;
      sendFail  <= 1'b0;
      routeFail <= 1'b0;
      rxValid   <= 1'b0;
      rxData    <= 8'h00;
      rxLast    <= 1'b0;
      rxCodeOk  <= 1'b0;
    end else begin
      tog       <= ~tog;
      txReady   <= slow ? tog : 1'b1;
      sendFail  <= 1'b0;
      routeFail <= 1'b0;
      rxValid   <= 1'b0;
      rxLast    <= 1'b0;
      rxData    <= ~rxData;
      if (txValid && txReady) begin
        held.push_back(txData);
        sendFail  <= mode == 3'h4;
        routeFail <= mode == 3'h5;
        echo      <= txLast && mode != 3'h1;
      end else if (!txValid && !echo) begin
        held.delete();
      end
      if (echo && held.size() > 0) begin
        rxValid  <= 1'b1;
        rxLast   <= held.size() == 1;
        echo     <= held.size() > 1;
        rxCodeOk <= mode != 3'h2;
        rxData   <= held.pop_front() ^ {7'h00, mode == 3'h3};
      end
    end
  end
endmodule : ilte_remote

// >>> bench/internode_link_test_engine_bench.sv
// bench for the link test engine: APB host, remote model, scenarios
// assumes the engine, its package and the remote model compile first
`timescale 1ns/1ns
module internode_link_test_engine_bench;
  localparam int UNIT = 3;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, txValid, txReady, txLast;
  logic        sendFail, routeFail, rxValid, rxLast, rxCodeOk, ind;
  logic [7:0]  txData, rxData;
  logic [15:0] txDest, pbw, cwa, dst;
  logic [2:0]  mode = 3'h0;
  logic        slow = 1'b0;
  int          n_errors = 0, checks = 0, bytes = 0, lastLen = 0, gap = 0, lastGap = 0;

  always #5 clk = ~clk;

  ilte_engine #(.UNIT_NUMBER(UNIT), .TMO_UNIT_CYCLES(10)) dut_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txValid(txValid), .txReady(txReady), .txData(txData),
    .txLast(txLast), .txDest(txDest), .sendFail(sendFail), .routeFail(routeFail),
    .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxCodeOk(rxCodeOk),
    .testRunningIndicator(ind), .paramBlockWord(pbw), .ctrlWordAddr(cwa));

  ilte_remote rem_u (
    .clk(clk), .rst(rst), .mode(mode), .slow(slow), .txValid(txValid),
    .txReady(txReady), .txData(txData), .txLast(txLast), .sendFail(sendFail),
    .routeFail(routeFail), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast),
    .rxCodeOk(rxCodeOk));

  // frame length and cycles between frame ends
  always @(posedge clk) begin
    gap <= (txValid && txReady && txLast) ? 0 : gap + 1;
    if (!txValid) begin
      bytes <= 0;
    end else if (txReady) begin
      bytes <= txLast ? 0 : bytes + 1;
      if (txLast) begin
        lastLen <= bytes + 1;
        lastGap <= gap + 1;
      end
    end
  end

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic e);
    int i;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      wrap_up();
    end
    rdv = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [15:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, idx, {16'h0000, v}, d, e);
  endtask : wr

  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rdc

  task automatic waitRuns(input int n);
    int i;
    for (i = 0; i < 3000; i++) begin
      apb(1'b0, ilte_pkg::IDX_RUNS, 32'h0, rd, err);
      if (rd[15:0] >= n) break;
    end
    if (i == 3000) begin
      n_errors++;
      wrap_up();
    end
  endtask : waitRuns

  task automatic runCase(input logic [2:0] m, input int n);
    mode <= m;
    wr(ilte_pkg::IDX_CTRL, 16'h0002);
    waitRuns(n);
    chk({31'h0, ind}, 32'h1);
    dst = txDest;
    wr(ilte_pkg::IDX_CTRL, 16'h0000);
    repeat (2) @(posedge clk);
    chk({31'h0, ind}, 32'h0);
  endtask : runCase

  task automatic s_normal;
    logic [31:0] r;
    wr(ilte_pkg::IDX_TARGET, 16'h0102);
    chk({16'h0, pbw}, 32'(2000 + 100 * UNIT));
    chk({16'h0, cwa}, 32'(1500 + 25 * UNIT));
    wr(ilte_pkg::IDX_LENGTH, 16'h0004);
    wr(ilte_pkg::IDX_TIMEOUT, 16'h0002);
    rdc(ilte_pkg::IDX_LENGTH, 32'h00000004);
    rdc(ilte_pkg::IDX_TIMEOUT, 32'h00000002);
    apb(1'b0, 6'h0A, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    slow <= 1'b1;
    runCase(3'h0, 3);
    chk({16'h0, dst}, 32'h00000102);
    rdc(ilte_pkg::IDX_STATUS, 32'h0);
    chk(lastLen, 32'h00000004);
    apb(1'b0, ilte_pkg::IDX_RUNS, 32'h0, r, err);
    wr(ilte_pkg::IDX_RUNS, 16'h1234);
    repeat (20) @(posedge clk);
    rdc(ilte_pkg::IDX_RUNS, r);
    slow <= 1'b0;
  endtask : s_normal

  task automatic s_codes;
    logic [2:0]  modes[7] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5, 3'h6, 3'h0};
    logic [31:0] r;
    int          i, k;
    for (i = 0; i < 7; i++) begin
      wr(ilte_pkg::IDX_TARGET, i == 5 ? 16'h01FF : 16'h0102);
      runCase(modes[i], 2);
      if (i == 0) chk(lastGap >= 20 && lastGap < 40, 32'h1);
      rdc(ilte_pkg::IDX_STATUS, i < 6 ? 32'((i + 1) << 13) | (32'h1 << i) : 32'h0);
      apb(1'b0, ilte_pkg::IDX_RUNS, 32'h0, r, err);
      for (k = 0; k < 4; k++) begin
        rdc(6'(5 + k), (k == i) ? r : 32'h0);
      end
    end
  endtask : s_codes

  task automatic s_limits;
    logic [31:0] r;
    wr(ilte_pkg::IDX_TIMEOUT, 16'h0000);
    runCase(3'h1, 2);
    chk(lastGap >= 2000 && lastGap < 2020, 32'h1);
    wr(ilte_pkg::IDX_TIMEOUT, 16'h0002);
    wr(ilte_pkg::IDX_LENGTH, 16'h0000);
    mode <= 3'h0;
    wr(ilte_pkg::IDX_CTRL, 16'h0002);
    waitRuns(1);
    chk(lastLen, 32'h000007CC);
    wr(ilte_pkg::IDX_LENGTH, 16'h0007);
    apb(1'b0, ilte_pkg::IDX_RUNS, 32'h0, r, err);
    waitRuns(r[15:0] + 2);
    wr(ilte_pkg::IDX_CTRL, 16'h0000);
    chk(lastLen, 32'h00000007);
  endtask : s_limits

  // illegal target: one counted run per cycle, long enough for the run counter to wrap
  task automatic s_wrap;
    int k;
    wr(ilte_pkg::IDX_TARGET, 16'h01FF);
    wr(ilte_pkg::IDX_CTRL, 16'h0002);
    repeat (65600) @(posedge clk);
    wr(ilte_pkg::IDX_CTRL, 16'h0000);
    apb(1'b0, ilte_pkg::IDX_RUNS, 32'h0, rd, err);
    chk({31'h0, rd[15:0] < 16'h0100}, 32'h1);
    rdc(ilte_pkg::IDX_STATUS, 32'h0000C020);
    for (k = 0; k < 4; k++) begin
      rdc(6'(5 + k), 32'h0);
    end
  endtask : s_wrap

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    s_normal();
    s_codes();
    s_limits();
    s_wrap();
    wrap_up();
  end
endmodule : internode_link_test_engine_bench
